// [hw/ifel_pkg.sv]
// Purpose: Shared constants for the interrupt flag and enable logic
// Assumes: 8-bit register port, one clock
// Notes: Vectors are program addresses handed to the core
package ifel_pkg;
  localparam logic [7:0] ADDR_CORE_STAT = 8'h07;
  localparam logic [7:0] ADDR_PENA_TWO = 8'h11;
  localparam logic [7:0] ADDR_PREQ_ONE = 8'h16;
  localparam logic [7:0] ADDR_PENA_ONE = 8'h17;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h20;
  // Core status/control bit positions
  localparam int BIT_PEND = 7;
  localparam int BIT_CLK_F = 6;
  localparam int BIT_T0_F = 5;
  localparam int BIT_EXT_F = 4;
  localparam int BIT_PERIPH_GLOBAL_ENABLE = 3;
  // Peripheral request one bit positions, and the unused enable two bit
  localparam int BIT_PORTB = 7;
  localparam int BIT_TMR3 = 6;
  localparam int BIT_TMR2 = 5;
  localparam int BIT_TMR1 = 4;
  localparam int BIT_CAP2 = 3;
  localparam int BIT_CAP1 = 2;
  localparam int BIT_TX1 = 1;
  localparam int BIT_RX1 = 0;
  localparam int BIT_PE2_UNUSED = 4;
  // Mode control bit positions
  localparam int BIT_GID = 0;
  localparam int BIT_EXT_SEL = 1;
  localparam int BIT_CLK_SEL = 2;
  localparam int BIT_CAP1_SEL = 3;
  localparam int BIT_WIDE = 4;
  // Reset values and the enable two write mask
  localparam logic [3:0] RST_CORE_EN = 4'h0;
  localparam logic [7:0] RST_PENA = 8'h00;
  localparam logic [7:0] RST_PREQ = 8'h02;
  localparam logic [4:0] RST_MODE = 5'h01;
  localparam logic [7:0] PE2_MASK = 8'hEF;
  // Vectors
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_EXT = 16'h0008;
  localparam logic [15:0] VEC_T0 = 16'h0010;
  localparam logic [15:0] VEC_CLK = 16'h0018;
  localparam logic [15:0] VEC_PERIPH = 16'h0020;
endpackage

// [hw/ifel_top.sv]
// Purpose: Interrupt flags, enables, priority and vector request
// Assumes: All inputs synchronous to clk; event inputs are 1-cycle pulses
// Notes: Read data valid only in the cycle after reg_rd
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module ifel_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_r,
  input wire logic ext_int_pin,
  input wire logic timer0_clock_pin,
  input wire logic timer0_overflow,
  input wire logic portb_mismatch,
  input wire logic timer3_overflow,
  input wire logic timer3_period_roll,
  input wire logic timer2_period_roll,
  input wire logic timer1_period_roll,
  input wire logic timer_wide_roll,
  input wire logic capture1_event,
  input wire logic capture2_event,
  input wire logic serial1_tx_empty,
  input wire logic serial1_rx_full,
  input wire logic [7:0] periph2_flags,
  input wire logic core_ack,
  input wire logic core_retfie,
  output logic irq_request_r,
  output logic [15:0] irq_vector_r,
  output logic reset_jump_r
);

  logic [3:0] core_en_r;
  logic ext_edge_flag_r;
  logic timer0_overflow_flag_r;
  logic clkpin_edge_flag_r;
  logic [7:0] peripheral_enable_one_r;
  logic [7:0] peripheral_enable_two_r;
  logic [7:0] peripheral_request_one_r;
  logic [4:0] mode_r;
  logic ext_pin_r;
  logic clk_pin_r;
  logic pins_seen_r;
  logic wr_core;
  logic wr_pe1;
  logic wr_pe2;
  logic wr_pr1;
  logic wr_mode;
  logic ext_set;
  logic clk_set;
  logic [7:0] preq_set;
  logic periph_pending_flag;
  logic [7:0] core_view;
  logic take;
  logic [15:0] sel_vec;

  localparam int BIT_EXT_OFS = ifel_pkg::BIT_EXT_F;

  // Set beats software write and hardware clear in the same cycle
  function automatic logic flag_upd(input logic cur, input logic set,
                                    input logic wr, input logic wbit,
                                    input logic hclr);
    if (set)
      flag_upd = 1'b1;
    else if (wr)
      flag_upd = wbit;
    else if (hclr)
      flag_upd = 1'b0;
    else
      flag_upd = cur;
  endfunction

  // Highest-priority enabled request picks the vector
  function automatic logic [15:0] pick_vec(input logic [7:0] v);
    if (v[BIT_EXT_OFS] && v[0])
      pick_vec = ifel_pkg::VEC_EXT;
    else if (v[5] && v[1])
      pick_vec = ifel_pkg::VEC_T0;
    else if (v[6] && v[2])
      pick_vec = ifel_pkg::VEC_CLK;
    else
      pick_vec = ifel_pkg::VEC_PERIPH;
  endfunction

  assign wr_core = reg_wr && (reg_addr == ifel_pkg::ADDR_CORE_STAT);
  assign wr_pe1 = reg_wr && (reg_addr == ifel_pkg::ADDR_PENA_ONE);
  assign wr_pe2 = reg_wr && (reg_addr == ifel_pkg::ADDR_PENA_TWO);
  assign wr_pr1 = reg_wr && (reg_addr == ifel_pkg::ADDR_PREQ_ONE);
  assign wr_mode = reg_wr && (reg_addr == ifel_pkg::ADDR_MODE_CTRL);

  // Edge detection; pins_seen_r masks a false edge after reset
  assign ext_set = pins_seen_r &&
    (mode_r[ifel_pkg::BIT_EXT_SEL] ? (ext_int_pin && !ext_pin_r)
                                   : (!ext_int_pin && ext_pin_r));
  assign clk_set = pins_seen_r &&
    (mode_r[ifel_pkg::BIT_CLK_SEL] ? (timer0_clock_pin && !clk_pin_r)
                                   : (!timer0_clock_pin && clk_pin_r));

  always_comb begin
    preq_set = 8'h00;
    preq_set[ifel_pkg::BIT_PORTB] = portb_mismatch;
    preq_set[ifel_pkg::BIT_TMR3] = mode_r[ifel_pkg::BIT_CAP1_SEL] ?
      timer3_overflow : timer3_period_roll;
    preq_set[ifel_pkg::BIT_TMR2] = timer2_period_roll;
    preq_set[ifel_pkg::BIT_TMR1] = mode_r[ifel_pkg::BIT_WIDE] ?
      timer_wide_roll : timer1_period_roll;
    preq_set[ifel_pkg::BIT_CAP2] = capture2_event;
    preq_set[ifel_pkg::BIT_CAP1] = capture1_event;
  end

  // Peripheral pending flag needs an enabled request but ignores the global disable
  assign periph_pending_flag =
    |(peripheral_request_one_r & peripheral_enable_one_r) ||
    |(periph2_flags & peripheral_enable_two_r);

  assign core_view = {periph_pending_flag, clkpin_edge_flag_r,
                      timer0_overflow_flag_r, ext_edge_flag_r, core_en_r};

  // Peripheral requests count only with the global peripheral enable
  assign take = !mode_r[ifel_pkg::BIT_GID] &&
    |(core_view[7:4] & core_view[3:0]);
  assign sel_vec = pick_vec(core_view);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_pin_r <= 1'b0;
      clk_pin_r <= 1'b0;
      pins_seen_r <= 1'b0;
    end else begin
      ext_pin_r <= ext_int_pin;
      clk_pin_r <= timer0_clock_pin;
      pins_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      core_en_r <= ifel_pkg::RST_CORE_EN;
    else if (wr_core)
      core_en_r <= reg_wdata[3:0];
  end

  // Hardware clear happens when the core takes the matching vector
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_edge_flag_r <= 1'b0;
      timer0_overflow_flag_r <= 1'b0;
      clkpin_edge_flag_r <= 1'b0;
    end else begin
      ext_edge_flag_r <= flag_upd(ext_edge_flag_r, ext_set, wr_core,
        reg_wdata[ifel_pkg::BIT_EXT_F],
        core_ack && irq_request_r &&
        irq_vector_r == ifel_pkg::VEC_EXT);
      timer0_overflow_flag_r <= flag_upd(timer0_overflow_flag_r,
        timer0_overflow, wr_core, reg_wdata[ifel_pkg::BIT_T0_F],
        core_ack && irq_request_r &&
        irq_vector_r == ifel_pkg::VEC_T0);
      clkpin_edge_flag_r <= flag_upd(clkpin_edge_flag_r, clk_set,
        wr_core, reg_wdata[ifel_pkg::BIT_CLK_F],
        core_ack && irq_request_r &&
        irq_vector_r == ifel_pkg::VEC_CLK);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      peripheral_enable_one_r <= ifel_pkg::RST_PENA;
      peripheral_enable_two_r <= ifel_pkg::RST_PENA;
    end else begin
      if (wr_pe1)
        peripheral_enable_one_r <= reg_wdata;
      if (wr_pe2)
        peripheral_enable_two_r <=
          reg_wdata & ifel_pkg::PE2_MASK;
    end
  end

  // Upper six flags are software writable; low two mirror the serial port
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      peripheral_request_one_r <= ifel_pkg::RST_PREQ;
    end else begin
      for (int i = 2; i < 8; i++) begin
        peripheral_request_one_r[i] <= flag_upd(peripheral_request_one_r[i],
          preq_set[i], wr_pr1, reg_wdata[i], 1'b0);
      end
      peripheral_request_one_r[ifel_pkg::BIT_TX1] <=
        serial1_tx_empty;
      peripheral_request_one_r[ifel_pkg::BIT_RX1] <=
        serial1_rx_full;
    end
  end

  // Taking an interrupt sets the global disable, return clears it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_r <= ifel_pkg::RST_MODE;
    end else begin
      if (wr_mode)
        mode_r <= reg_wdata[4:0];
      if (core_ack && irq_request_r)
        mode_r[ifel_pkg::BIT_GID] <= 1'b1;
      else if (core_retfie)
        mode_r[ifel_pkg::BIT_GID] <= 1'b0;
    end
  end

  // Request drops in the cycle after an accepted ack
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_request_r <= 1'b0;
      irq_vector_r <= ifel_pkg::VEC_RESET;
    end else begin
      irq_request_r <= take && !(core_ack && irq_request_r);
      irq_vector_r <= sel_vec;
    end
  end

  // Clearing an enable while its flag is up misleads the core's vectoring
  always_ff @(posedge clk) begin
    if (!rst_b)
      reset_jump_r <= 1'b0;
    else
      reset_jump_r <= wr_core && !mode_r[ifel_pkg::BIT_GID] &&
        |(core_en_r & ~reg_wdata[3:0] &
          (core_view[7:4] | {1'b0, clk_set, timer0_overflow, ext_set}));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ifel_pkg::ADDR_CORE_STAT: reg_rdata_r <= core_view;
        ifel_pkg::ADDR_PENA_ONE: reg_rdata_r <= peripheral_enable_one_r;
        ifel_pkg::ADDR_PENA_TWO: reg_rdata_r <= peripheral_enable_two_r;
        ifel_pkg::ADDR_PREQ_ONE: reg_rdata_r <= peripheral_request_one_r;
        ifel_pkg::ADDR_MODE_CTRL: reg_rdata_r <= {3'h0, mode_r};
        default: reg_rdata_r <= 8'h00;
      endcase
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

endmodule

// [tb/ifel_top_monitor.sv]
// Purpose: Port checks for the interrupt flag and enable logic
// Assumes: One clock, synchronous active-low reset
// Notes: Sees top ports only; bound below
`timescale 1ns/100ps
module ifel_top_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_r,
  input wire logic serial1_tx_empty,
  input wire logic serial1_rx_full,
  input wire logic core_ack,
  input wire logic irq_request_r,
  input wire logic [15:0] irq_vector_r,
  input wire logic reset_jump_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_drops_req: assert property (
    core_ack && irq_request_r |=> !irq_request_r ##1 !irq_request_r)
    else $error("request stayed up after ack");
  a_reset_quiet: assert property (
    $rose(rst_b) |-> !irq_request_r ##1 !irq_request_r)
    else $error("request right after reset");
  a_jump_single: assert property (
    reset_jump_r |=> !reset_jump_r)
    else $error("reset jump longer than one cycle");
  a_vec_legal: assert property (
    irq_request_r |-> irq_vector_r inside
      {16'h0008, 16'h0010, 16'h0018, 16'h0020})
    else $error("request with odd vector");
  a_gap_bit_zero: assert property (
    reg_rd && reg_addr == 8'h11 |=> !reg_rdata_r[4])
    else $error("unused enable bit read as one");
  a_tx_mirror: assert property (
    reg_rd && reg_addr == 8'h16 |=>
      reg_rdata_r[1] == $past(serial1_tx_empty, 2))
    else $error("transmit flag not mirrored");
  a_rx_mirror: assert property (
    reg_rd && reg_addr == 8'h16 |=>
      reg_rdata_r[0] == $past(serial1_rx_full, 2))
    else $error("receive flag not mirrored");
  a_enable_echo: assert property (
    reg_wr && reg_addr == 8'h17 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h17
      |=> reg_rdata_r == $past(reg_wdata, 3))
    else $error("enable one readback differs");
  c_ack: cover property (core_ack && irq_request_r);
  c_jump: cover property (reset_jump_r);
  c_echo: cover property (reg_wr && reg_addr == 8'h17 ##2 reg_rd);
endmodule
bind ifel_top ifel_top_monitor ifel_top_monitor_i (.clk(clk),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
  .serial1_tx_empty(serial1_tx_empty), .serial1_rx_full(serial1_rx_full),
  .core_ack(core_ack), .irq_request_r(irq_request_r),
  .irq_vector_r(irq_vector_r), .reset_jump_r(reset_jump_r));

// [tb/ifel_core_model.sv]
// Purpose: Core sequencer model that takes and returns from interrupts
// Assumes: Acks a standing request after lag cycles
// Notes: Return comes 16 minus lag cycles after the ack
`timescale 1ns/100ps
module ifel_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic irq_request_r,
  input wire logic [3:0] lag,
  output logic core_ack,
  output logic core_retfie
);
  logic [3:0] wait_r;
  logic busy_r;
  always_ff @(posedge clk) begin
    core_ack <= 1'b0;
    core_retfie <= 1'b0;
    if (!rst_b) begin
      wait_r <= 4'h0;
      busy_r <= 1'b0;
    end else if (busy_r) begin
      // Routine lasts 16 minus lag cycles; software clears must land inside it
      wait_r <= wait_r + 4'h1;
      if (wait_r == 4'hF) begin
        core_retfie <= 1'b1;
        busy_r <= 1'b0;
      end
    end else if (!irq_request_r || core_ack) begin
      wait_r <= 4'h0;
    end else if (wait_r >= lag) begin
      core_ack <= 1'b1;
      busy_r <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// [tb/test_ifel_top.sv]
// Purpose: Self-checking bench for the interrupt flag and enable logic
// Assumes: Core model acks; bench plays software and peripherals
// Notes: Random enable data from a fixed seed
`timescale 1ns/100ps
module test_ifel_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ext_pin = 1'b1, clk_pin = 1'b1;
  logic portb = 1'b0, rx_full = 1'b0, core_ack, core_retfie;
  logic irq_request_r, reset_jump_r;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ev = 8'h00, d;
  logic [7:0] reg_rdata_r;
  logic [15:0] irq_vector_r;
  logic [3:0] lag = 4'h0;
  logic [15:0] vq[$];
  logic [7:0] ra[6] = '{8'h07, 8'h11, 8'h16, 8'h17, 8'h20, 8'h33};
  logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00};
  logic [15:0] ve[4] = '{16'h0008, 16'h0010, 16'h0018, 16'h0020};
  int mismatches = 0, total_checks = 0, jumps = 0, i;
  always #12.5 clk = ~clk;
  ifel_top ifel_top_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .ext_int_pin(ext_pin),
    .timer0_clock_pin(clk_pin), .timer0_overflow(ev[0]),
    .portb_mismatch(portb), .timer3_overflow(ev[1]),
    .timer3_period_roll(ev[2]), .timer2_period_roll(ev[3]),
    .timer1_period_roll(ev[4]), .timer_wide_roll(ev[5]),
    .capture1_event(ev[6]), .capture2_event(ev[7]),
    .serial1_tx_empty(1'b1), .serial1_rx_full(rx_full),
    .periph2_flags(8'h00), .core_ack(core_ack), .core_retfie(core_retfie),
    .irq_request_r(irq_request_r), .irq_vector_r(irq_vector_r),
    .reset_jump_r(reset_jump_r));
  ifel_core_model ifel_core_model_i (.clk(clk), .rst_b(rst_b),
    .irq_request_r(irq_request_r), .lag(lag), .core_ack(core_ack),
    .core_retfie(core_retfie));
  always @(posedge clk) begin
    if (core_ack === 1'b1 && irq_request_r === 1'b1) vq.push_back(irq_vector_r);
    if (reset_jump_r === 1'b1) jumps++;
  end
  task check(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check({8'h00, reg_rdata_r}, {8'h00, e});
  endtask
  task pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8F87A4B0));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 6; i++) rd(ra[i], rv[i]);
    done("reset");
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(8'h17, d);
      rd(8'h17, d);
      wr(8'h11, d);
      rd(8'h11, d & 8'hEF);
    end
    wr(8'h17, 8'h00);
    wr(8'h11, 8'h00);
    done("enables");
    @(posedge clk);
    ext_pin <= 1'b0;
    clk_pin <= 1'b0;
    rx_full <= 1'b1;
    pulse(8'hEB);
    rd(8'h07, 8'h70);
    rd(8'h16, 8'h2F);
    wr(8'h20, 8'h18);
    pulse(8'h36);
    rd(8'h16, 8'h7F);
    done("flags");
    @(posedge clk);
    portb <= 1'b1;
    wr(8'h16, 8'h00);
    rd(8'h16, 8'h83);
    @(posedge clk);
    portb <= 1'b0;
    wr(8'h16, 8'h00);
    rd(8'h16, 8'h03);
    wr(8'h07, 8'h00);
    rd(8'h07, 8'h00);
    done("clear");
    wr(8'h20, 8'h19);
    wr(8'h16, 8'h20);
    wr(8'h17, 8'h20);
    wr(8'h07, 8'h7F);
    wr(8'h20, 8'h18);
    for (i = 0; i < 400 && vq.size() < 4; i++) @(posedge clk);
    if (vq.size() < 4) begin
      mismatches++;
      wrap_up();
    end
    for (i = 0; i < 4; i++) check(vq[i], ve[i]);
    rd(8'h07, 8'h8F);
    wr(8'h16, 8'h00);
    rd(8'h07, 8'h0F);
    done("priority");
    wr(8'h07, 8'h07);
    wr(8'h16, 8'h20);
    rd(8'h07, 8'h87);
    repeat (20) @(posedge clk);
    check(16'(vq.size()), 16'h0004);
    done("gate");
    @(posedge clk);
    lag <= 4'hF;
    wr(8'h07, 8'h0F);
    wr(8'h07, 8'h07);
    repeat (4) @(posedge clk);
    check(16'(jumps), 16'h0001);
    done("jump");
    wrap_up();
  end
endmodule
